// File: pkg/i2cim_params.svh
// offsets, field positions, reset values and sizes of the irq mask/status block
`ifndef I2CIM_PARAMS_SVH
`define I2CIM_PARAMS_SVH

`define I2CIM_ADDR_W 32
`define I2CIM_DATA_W 16
`define I2CIM_NFLAGS 12

`define I2CIM_OFS_MASKED_STAT 32'h5000132C
`define I2CIM_OFS_MASK 32'h50001330
`define I2CIM_OFS_RAW_STAT 32'h50001334
`define I2CIM_OFS_RX_THRESHOLD_LEVEL 32'h50001338
`define I2CIM_OFS_TX_TL 32'h5000133C
`define I2CIM_OFS_CLR_ALL 32'h50001340
`define I2CIM_OFS_CLR_RD_REQ 32'h50001350
`define I2CIM_OFS_CLR_TRANSMIT_ABORT_FLAG 32'h50001354
`define I2CIM_OFS_CLR_ACTIVITY 32'h5000135C
`define I2CIM_OFS_CLR_GENERAL_CALL_FLAG 32'h50001368
`define I2CIM_OFS_ABORT_CAUSE 32'h50001380

`define I2CIM_BIT_GENERAL_CALL_FLAG 11
`define I2CIM_BIT_START 10
`define I2CIM_BIT_STOP 9
`define I2CIM_BIT_ACTIVITY 8
`define I2CIM_BIT_TX_DONE 7
`define I2CIM_BIT_TX_ABORT 6
`define I2CIM_BIT_RD_REQ 5
`define I2CIM_BIT_TX_LEVEL 4
`define I2CIM_BIT_TX_OVER 3
`define I2CIM_BIT_RX_LEVEL 2
`define I2CIM_BIT_RX_OVER 1
`define I2CIM_BIT_RX_UNDER 0

`define I2CIM_MASK_RESET 12'h8FF
`define I2CIM_TL_W 5
`define I2CIM_TL_RESET 5'h00
`define I2CIM_FIFO_DEPTH 32
`define I2CIM_LEVEL_W 6
`define I2CIM_CAUSE_W 16

`endif

// File: pkg/i2cim_pkg.sv
// types shared by the irq mask/status block
package i2cim_pkg;

    // one-cycle event strobes from the controller's own logic
    typedef struct packed {
        logic general_call_flag_ack;
        logic start_seen;
        logic stop_seen;
        logic slv_tx_nack;
        logic tx_abort;
        logic rd_req;
        logic tx_push;
        logic rx_push;
        logic rx_pop;
    } i2cim_events_type;

    // peripheral bus request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [15:0] pwdata;
    } i2cim_apb_req_type;

endpackage

// File: test/i2cim_remote.sv
// far-side i2c party: each bus happening reaches the controller as a pulse
`timescale 1ns/1ps

module i2cim_remote (
    // clock
    input wire logic clk_i,
    // command from the bench
    input wire logic go_i,
    input wire logic [3:0] kind_i,
    // events seen by the controller
    output i2cim_pkg::i2cim_events_type events_o
);
    initial events_o = '0;

    // one cycle only: a held pulse would count as repeated happenings
    always @(posedge clk_i) begin
        events_o <= #1 go_i ? i2cim_pkg::i2cim_events_type'(9'h100 >> kind_i)
                            : '0;
    end
endmodule

// File: test/i2cim_top_properties.sv
// concurrent checks on the ports of the irq mask/status block
`timescale 1ns/1ps
`include "i2cim_params.svh"

module i2cim_properties #(
    parameter int DEPTH = `I2CIM_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // peripheral bus
    input wire i2cim_pkg::i2cim_apb_req_type apb_i,
    input wire logic pready_o,
    // controller side
    input wire logic controller_enabled_i,
    input wire i2cim_pkg::i2cim_events_type events_i,
    input wire logic [`I2CIM_LEVEL_W-1:0] rx_level_i,
    input wire logic tx_fifo_flush_o,
    input wire logic scl_hold_o,
    input wire logic rx_drop_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////
    // read of the read request clear register: setup, then access
    sequence s_clr_rdreq;
        apb_i.psel && !apb_i.penable && !apb_i.pwrite &&
            apb_i.paddr == `I2CIM_OFS_CLR_RD_REQ ##1
            apb_i.psel && apb_i.penable;
    endsequence

    sequence s_no_access;
        !(apb_i.psel && apb_i.penable);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_rdreq_hold: assert property (events_i.rd_req |=> scl_hold_o)
        else $error("clock not held after read request");
    a_hold_sticky: assert property (scl_hold_o ##0 s_no_access |=> scl_hold_o)
        else $error("clock hold dropped without a clear read");
    a_rdreq_clear: assert property (
        s_clr_rdreq ##0 !events_i.rd_req |=> !scl_hold_o)
        else $error("clock hold stays after clear read");
    a_abort_flush: assert property (events_i.tx_abort |=> tx_fifo_flush_o)
        else $error("fifo not flushed after abort");
    a_flush_stays: assert property (
        $past(resetn_i) && $past(controller_enabled_i) && tx_fifo_flush_o
        ##0 s_no_access |=> tx_fifo_flush_o)
        else $error("abort flush released without a clear read");
    a_off_flush: assert property (!controller_enabled_i |=> tx_fifo_flush_o)
        else $error("fifo not flushed while disabled");
    a_drop_full: assert property (
        events_i.rx_push && rx_level_i == 6'(DEPTH) |=> rx_drop_o)
        else $error("byte into full fifo not dropped");
    a_drop_cause: assert property (
        rx_drop_o |-> $past(events_i.rx_push) && $past(rx_level_i) == 6'(DEPTH))
        else $error("byte dropped without a full fifo");
    // no wait states: a stalled bus would hide every clear side effect
    a_ready_up: assert property ($past(resetn_i) |-> pready_o)
        else $error("ready low outside reset");
endmodule

bind i2cim_top i2cim_properties #(.DEPTH(DEPTH)) i_i2cim_properties (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .apb_i(apb_i),
    .pready_o(pready_o),
    .controller_enabled_i(controller_enabled_i),
    .events_i(events_i),
    .rx_level_i(rx_level_i),
    .tx_fifo_flush_o(tx_fifo_flush_o),
    .scl_hold_o(scl_hold_o),
    .rx_drop_o(rx_drop_o)
);

// File: test/i2cim_top_test.sv
// self-checking bench for the irq mask/status block
`timescale 1ns/1ps
`include "i2cim_params.svh"

module i2cim_top_test;
    logic clk_i = 0;
    logic resetn_i = 0;
    i2cim_pkg::i2cim_apb_req_type apb = '0;
    logic en = 1;
    logic act = 0;
    logic go = 0;
    logic [3:0] kind = 4'h0;
    logic [15:0] cause = 16'h0042;
    logic [5:0] txl = 6'h05;
    logic [5:0] rxl = 6'h00;
    logic [15:0] prdata;
    logic pready, flush, hold, drop, irq;
    i2cim_pkg::i2cim_events_type ev;
    int err_count = 0;
    int num_checks = 0;
    int drops = 0;

    always #5 clk_i = ~clk_i;

    // drop is a one-cycle pulse, so it is counted at every edge
    always @(posedge clk_i) begin
        if (drop === 1'b1) begin
            drops++;
        end
    end

    i2cim_top i_i2cim_top (.clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb),
        .prdata_o(prdata), .pready_o(pready), .controller_enabled_i(en),
        .sm_active_i(act), .events_i(ev), .abort_cause_i(cause),
        .tx_level_i(txl), .rx_level_i(rxl), .tx_fifo_flush_o(flush),
        .scl_hold_o(hold), .rx_drop_o(drop), .irq_o(irq));
    i2cim_remote i_i2cim_remote (.clk_i(clk_i), .go_i(go), .kind_i(kind),
        .events_o(ev));

    ////////////////////////////////////////////////////////////////////////
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task xfer(input logic w, input logic [31:0] a, input logic [15:0] wd,
              output logic [15:0] rd);
        int n;
        n = 0;
        apb.psel = 1;
        apb.penable = 0;
        apb.pwrite = w;
        apb.paddr = a;
        apb.pwdata = wd;
        cyc(1);
        apb.penable = 1;
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        rd = prdata;
        #1;
        apb = '0;
        // idle cycle so back-to-back calls never drive psel twice at once
        cyc(1);
        if (n == 8) begin
            err_count++;
            $display("[ERR] %0t bus never ready", $time);
            close_out();
        end
    endtask

    task wr(input logic [31:0] a, input logic [15:0] d);
        logic [15:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task rd(input logic [31:0] a, input logic [15:0] e);
        logic [15:0] x;
        xfer(1'b0, a, 16'h0000, x);
        chk(x, e);
    endtask

    // one bus happening, then enough cycles for flag and irq to land
    task ev_go(input logic [3:0] k);
        kind = k;
        go = 1;
        cyc(1);
        go = 0;
        cyc(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(12);
        resetn_i = 1;
        cyc(1);
        rd(`I2CIM_OFS_MASK, 16'h08FF);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0000);
        rd(32'h50001300, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        $display("test reset done");
        ev_go(4'h0);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0800);
        rd(`I2CIM_OFS_MASKED_STAT, 16'h0800);
        chk({15'h0, irq}, 16'h0001);
        rd(`I2CIM_OFS_CLR_GENERAL_CALL_FLAG, 16'h0001);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0000);
        $display("test general call done");
        ev_go(4'h1);
        ev_go(4'h2);
        act = 1;
        cyc(1);
        act = 0;
        cyc(2);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0700);
        rd(`I2CIM_OFS_MASKED_STAT, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        ev_go(4'h3);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0780);
        rd(`I2CIM_OFS_MASKED_STAT, 16'h0080);
        chk({15'h0, irq}, 16'h0001);
        rd(`I2CIM_OFS_CLR_ACTIVITY, 16'h0001);
        rd(`I2CIM_OFS_CLR_ALL, 16'h0001);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0000);
        $display("test start stop activity done");
        ev_go(4'h5);
        chk({15'h0, hold}, 16'h0001);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0020);
        ev_go(4'h6);
        chk({15'h0, hold}, 16'h0001);
        rd(`I2CIM_OFS_CLR_RD_REQ, 16'h0001);
        chk({15'h0, hold}, 16'h0000);
        $display("test read request done");
        ev_go(4'h4);
        chk({15'h0, flush}, 16'h0001);
        rd(`I2CIM_OFS_ABORT_CAUSE, 16'h0042);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0040);
        rd(`I2CIM_OFS_CLR_TRANSMIT_ABORT_FLAG, 16'h0001);
        cyc(1);
        chk({15'h0, flush}, 16'h0000);
        rd(`I2CIM_OFS_ABORT_CAUSE, 16'h0000);
        $display("test abort done");
        wr(`I2CIM_OFS_TX_TL, 16'hFFE5);
        cyc(2);
        rd(`I2CIM_OFS_TX_TL, 16'h0005);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0010);
        txl = 6'h06;
        cyc(2);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0000);
        $display("test tx threshold done");
        rxl = 6'h20;
        ev_go(4'h7);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0006);
        chk(16'(drops), 16'h0001);
        rxl = 6'h00;
        ev_go(4'h8);
        txl = 6'h20;
        ev_go(4'h6);
        rd(`I2CIM_OFS_RAW_STAT, 16'h000B);
        en = 0;
        cyc(3);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0000);
        chk({15'h0, flush}, 16'h0001);
        act = 1;
        cyc(2);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0110);
        act = 0;
        cyc(2);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0000);
        en = 1;
        $display("test fifo errors done");
        wr(`I2CIM_OFS_MASK, 16'hFFFF);
        rd(`I2CIM_OFS_MASK, 16'h0FFF);
        wr(`I2CIM_OFS_MASK, 16'h0000);
        ev_go(4'h1);
        chk({15'h0, irq}, 16'h0000);
        rd(`I2CIM_OFS_MASKED_STAT, 16'h0000);
        wr(`I2CIM_OFS_RAW_STAT, 16'hFFFF);
        rd(`I2CIM_OFS_RAW_STAT, 16'h0400);
        wr(`I2CIM_OFS_MASK, 16'h0400);
        cyc(2);
        chk({15'h0, irq}, 16'h0001);
        $display("test mask done");
        close_out();
    end
endmodule

// File: verilog/i2cim_flag.sv
// one status flag with set and clear, set winning
`timescale 1ns/1ps

module i2cim_flag (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // control
    input wire logic set_i,
    input wire logic clr_i,
    // state
    output logic flag_o
);

    logic flag_q;
    logic flag_d;

    // a set in the clear cycle is kept so no event is lost
    always_comb begin
        flag_d = flag_q;
        if (clr_i) begin
            flag_d = 1'b0;
        end
        if (set_i) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;

endmodule

// File: verilog/i2cim_top.sv
// irq mask, raw and masked status of the i2c controller, with apb access
//
// Notes on behaviour
// - mask bits gate flags; reset mask has bits 11 and 7..0 set.
// - general call flag sets on acked general call, clears on disable or read.
// - data after an accepted general call goes into the receive buffer.
// - start-seen flag sets on every start or repeated start.
// - stop-seen flag sets on every stop condition.
// - activity flag latches activity; clears on disable or clear reads once idle, and on reset.
// - slave transmit done flag sets when the master nacks a byte.
// - transmit abort flag sets on abort; abort cause is recorded.
// - transmit fifo stays flushed while abort flag is set.
// - read request flag sets when read as slave; clock held low meanwhile.
// - read request flag clears right after its clear register is read.
// - transmit level flag is one while fifo level is at or below threshold.
// - disabled, fifo is flushed; level flag follows state machine activity.
// - transmit overflow sets on push when full; clears disabled and idle.
// - receive level flag is set above threshold, cleared disabled.
// - receive overflow sets on byte arriving with a full fifo.
// - receive underflow sets on a read of an empty receive fifo.
`timescale 1ns/1ps
`include "i2cim_params.svh"

module i2cim_top #(
    parameter int DEPTH = `I2CIM_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // peripheral bus
    input wire i2cim_pkg::i2cim_apb_req_type apb_i,
    output logic [`I2CIM_DATA_W-1:0] prdata_o,
    output logic pready_o,
    // controller status
    input wire logic controller_enabled_i,
    input wire logic sm_active_i,
    input wire i2cim_pkg::i2cim_events_type events_i,
    input wire logic [`I2CIM_CAUSE_W-1:0] abort_cause_i,
    input wire logic [`I2CIM_LEVEL_W-1:0] tx_level_i,
    input wire logic [`I2CIM_LEVEL_W-1:0] rx_level_i,
    // controls back to the controller
    output logic tx_fifo_flush_o,
    output logic scl_hold_o,
    output logic rx_drop_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    logic rd_access;
    logic wr_access;
    logic setup;

    assign setup = apb_i.psel && !apb_i.penable;
    assign rd_access = apb_i.psel && apb_i.penable && !apb_i.pwrite;
    assign wr_access = apb_i.psel && apb_i.penable && apb_i.pwrite;

    logic clr_all;
    logic clr_general_call_flag;
    logic clr_activity;
    logic clr_abort;
    logic clr_rd_req;

    assign clr_all = rd_access && (apb_i.paddr == `I2CIM_OFS_CLR_ALL);
    assign clr_general_call_flag = rd_access
        && (apb_i.paddr == `I2CIM_OFS_CLR_GENERAL_CALL_FLAG);
    assign clr_activity = rd_access
        && (apb_i.paddr == `I2CIM_OFS_CLR_ACTIVITY);
    assign clr_abort = rd_access
        && (apb_i.paddr == `I2CIM_OFS_CLR_TRANSMIT_ABORT_FLAG);
    assign clr_rd_req = rd_access
        && (apb_i.paddr == `I2CIM_OFS_CLR_RD_REQ);

    ////////////////////////////////////////////////////////////////////////
    // software registers

    logic [`I2CIM_NFLAGS-1:0] mask_q;
    logic [`I2CIM_NFLAGS-1:0] mask_d;
    logic [`I2CIM_TL_W-1:0] tx_tl_q;
    logic [`I2CIM_TL_W-1:0] tx_tl_d;
    logic [`I2CIM_TL_W-1:0] rx_threshold_level_q;
    logic [`I2CIM_TL_W-1:0] rx_threshold_level_d;
    logic [`I2CIM_CAUSE_W-1:0] cause_q;
    logic [`I2CIM_CAUSE_W-1:0] cause_d;

    always_comb begin
        mask_d = mask_q;
        tx_tl_d = tx_tl_q;
        rx_threshold_level_d = rx_threshold_level_q;
        cause_d = cause_q;
        if (wr_access) begin
            case (apb_i.paddr)
                `I2CIM_OFS_MASK: begin
                    mask_d = apb_i.pwdata[`I2CIM_NFLAGS-1:0];
                end
                `I2CIM_OFS_TX_TL: begin
                    tx_tl_d = apb_i.pwdata[`I2CIM_TL_W-1:0];
                end
                `I2CIM_OFS_RX_THRESHOLD_LEVEL: begin
                    rx_threshold_level_d = apb_i.pwdata[`I2CIM_TL_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // cause kept until the abort is cleared, new abort overwrites
        if (clr_abort || clr_all) begin
            cause_d = '0;
        end
        if (events_i.tx_abort) begin
            cause_d = abort_cause_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mask_q <= `I2CIM_MASK_RESET;
            tx_tl_q <= `I2CIM_TL_RESET;
            rx_threshold_level_q <= `I2CIM_TL_RESET;
            cause_q <= '0;
        end else begin
            mask_q <= mask_d;
            tx_tl_q <= tx_tl_d;
            rx_threshold_level_q <= rx_threshold_level_d;
            cause_q <= cause_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag set and clear terms

    logic [`I2CIM_NFLAGS-1:0] set_v;
    logic [`I2CIM_NFLAGS-1:0] clr_v;
    logic [`I2CIM_NFLAGS-1:0] raw;
    logic disabled_idle;
    logic tx_full;
    logic rx_full;
    logic tx_at_or_below;
    logic rx_at_or_above;

    assign disabled_idle = !controller_enabled_i && !sm_active_i;
    assign tx_full = (tx_level_i == DEPTH[`I2CIM_LEVEL_W-1:0]);
    assign rx_full = (rx_level_i == DEPTH[`I2CIM_LEVEL_W-1:0]);
    // a 5-bit threshold never exceeds the fifo depth, so no clamp is needed
    assign tx_at_or_below = (tx_level_i <= {1'b0, tx_tl_q});
    assign rx_at_or_above = (rx_level_i >
        {1'b0, rx_threshold_level_q});

    always_comb begin
        set_v = '0;
        clr_v = '0;
        set_v[`I2CIM_BIT_GENERAL_CALL_FLAG] = events_i.general_call_flag_ack;
        clr_v[`I2CIM_BIT_GENERAL_CALL_FLAG] = !controller_enabled_i
            || clr_general_call_flag || clr_all;
        set_v[`I2CIM_BIT_START] = events_i.start_seen;
        clr_v[`I2CIM_BIT_START] = clr_all;
        set_v[`I2CIM_BIT_STOP] = events_i.stop_seen;
        clr_v[`I2CIM_BIT_STOP] = clr_all;
        set_v[`I2CIM_BIT_ACTIVITY] = sm_active_i;
        clr_v[`I2CIM_BIT_ACTIVITY] = !controller_enabled_i
            || clr_activity || clr_all;
        set_v[`I2CIM_BIT_TX_DONE] = events_i.slv_tx_nack;
        clr_v[`I2CIM_BIT_TX_DONE] = clr_all;
        set_v[`I2CIM_BIT_TX_ABORT] = events_i.tx_abort;
        clr_v[`I2CIM_BIT_TX_ABORT] = clr_abort || clr_all;
        set_v[`I2CIM_BIT_RD_REQ] = events_i.rd_req;
        clr_v[`I2CIM_BIT_RD_REQ] = clr_rd_req || clr_all;
        // level flag: disabled it only reflects state machine activity
        if (controller_enabled_i) begin
            set_v[`I2CIM_BIT_TX_LEVEL] = tx_at_or_below;
        end else begin
            set_v[`I2CIM_BIT_TX_LEVEL] = sm_active_i;
        end
        clr_v[`I2CIM_BIT_TX_LEVEL] = !set_v[`I2CIM_BIT_TX_LEVEL];
        set_v[`I2CIM_BIT_TX_OVER] = events_i.tx_push && tx_full;
        clr_v[`I2CIM_BIT_TX_OVER] = disabled_idle || clr_all;
        set_v[`I2CIM_BIT_RX_LEVEL] = controller_enabled_i
            && rx_at_or_above;
        clr_v[`I2CIM_BIT_RX_LEVEL] = !set_v[`I2CIM_BIT_RX_LEVEL];
        set_v[`I2CIM_BIT_RX_OVER] = events_i.rx_push && rx_full;
        clr_v[`I2CIM_BIT_RX_OVER] = disabled_idle || clr_all;
        set_v[`I2CIM_BIT_RX_UNDER] = events_i.rx_pop
            && (rx_level_i == '0);
        clr_v[`I2CIM_BIT_RX_UNDER] = disabled_idle || clr_all;
    end

    ////////////////////////////////////////////////////////////////////////
    // flags

    genvar g;
    generate
        for (g = 0; g < `I2CIM_NFLAGS; g = g + 1) begin : g_flag
            i2cim_flag u_flag (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .set_i(set_v[g]),
                .clr_i(clr_v[g]),
                .flag_o(raw[g])
            );
        end
    endgenerate

    logic [`I2CIM_NFLAGS-1:0] masked;

    assign masked = raw & mask_q;

    ////////////////////////////////////////////////////////////////////////
    // read data and control outputs

    logic [`I2CIM_DATA_W-1:0] prdata_q;
    logic [`I2CIM_DATA_W-1:0] prdata_d;
    logic pready_q;
    logic flush_q;
    logic flush_d;
    logic scl_hold_q;
    logic scl_hold_d;
    logic rx_drop_q;
    logic rx_drop_d;
    logic irq_q;
    logic irq_d;

    always_comb begin
        prdata_d = prdata_q;
        if (setup && !apb_i.pwrite) begin
            case (apb_i.paddr)
                `I2CIM_OFS_MASKED_STAT: begin
                    prdata_d = {{(`I2CIM_DATA_W-`I2CIM_NFLAGS){1'b0}},
                        masked};
                end
                `I2CIM_OFS_MASK: begin
                    prdata_d = {{(`I2CIM_DATA_W-`I2CIM_NFLAGS){1'b0}},
                        mask_q};
                end
                `I2CIM_OFS_RAW_STAT: begin
                    prdata_d = {{(`I2CIM_DATA_W-`I2CIM_NFLAGS){1'b0}}, raw};
                end
                `I2CIM_OFS_TX_TL: begin
                    prdata_d = {{(`I2CIM_DATA_W-`I2CIM_TL_W){1'b0}},
                        tx_tl_q};
                end
                `I2CIM_OFS_RX_THRESHOLD_LEVEL: begin
                    prdata_d = {{(`I2CIM_DATA_W-`I2CIM_TL_W){1'b0}},
                        rx_threshold_level_q};
                end
                `I2CIM_OFS_ABORT_CAUSE: begin
                    prdata_d = cause_q;
                end
                `I2CIM_OFS_CLR_GENERAL_CALL_FLAG: begin
                    prdata_d = {{(`I2CIM_DATA_W-1){1'b0}},
                        raw[`I2CIM_BIT_GENERAL_CALL_FLAG]};
                end
                `I2CIM_OFS_CLR_ACTIVITY: begin
                    prdata_d = {{(`I2CIM_DATA_W-1){1'b0}},
                        raw[`I2CIM_BIT_ACTIVITY]};
                end
                `I2CIM_OFS_CLR_TRANSMIT_ABORT_FLAG: begin
                    prdata_d = {{(`I2CIM_DATA_W-1){1'b0}},
                        raw[`I2CIM_BIT_TX_ABORT]};
                end
                `I2CIM_OFS_CLR_RD_REQ: begin
                    prdata_d = {{(`I2CIM_DATA_W-1){1'b0}},
                        raw[`I2CIM_BIT_RD_REQ]};
                end
                `I2CIM_OFS_CLR_ALL: begin
                    prdata_d = {{(`I2CIM_DATA_W-1){1'b0}}, |raw};
                end
                default: begin
                    prdata_d = '0;
                end
            endcase
        end
        // new abort or disable flushes at once, not a cycle late
        flush_d = !controller_enabled_i || set_v[`I2CIM_BIT_TX_ABORT]
            || (raw[`I2CIM_BIT_TX_ABORT]
            && !(clr_v[`I2CIM_BIT_TX_ABORT]));
        scl_hold_d = set_v[`I2CIM_BIT_RD_REQ]
            || (raw[`I2CIM_BIT_RD_REQ] && !clr_v[`I2CIM_BIT_RD_REQ]);
        // overflow byte is acked on the bus but never stored; general call
        // data passes like any other received byte
        rx_drop_d = events_i.rx_push && rx_full;
        irq_d = |masked;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            flush_q <= 1'b1;
            scl_hold_q <= 1'b0;
            rx_drop_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= 1'b1;
            flush_q <= flush_d;
            scl_hold_q <= scl_hold_d;
            rx_drop_q <= rx_drop_d;
            irq_q <= irq_d;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign tx_fifo_flush_o = flush_q;
    assign scl_hold_o = scl_hold_q;
    assign rx_drop_o = rx_drop_q;
    assign irq_o = irq_q;

endmodule
